// File: core/boundary_scan_tap.sv
/*
 * Boundary-scan test access port: controller, instruction register,
 * bypass, identification and boundary registers, and the hand-over
 * of test modes to the functional clock domain.
 * Assumes an external tester drives the test pins, and that the
 * sampled pin values are captured directly on the test clock, as a
 * boundary cell captures its pad.
 */

module boundary_scan_tap (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic test_clock,
	input wire logic test_reset_n,
	input wire logic test_mode_select,
	input wire logic test_serial_in,
	output logic test_serial_out,
	output logic testSerialOutEnable,
	input wire logic feature_set_select,
	input wire logic [tap_pkg::BSR_LENGTH-1:0] pinSample,
	input wire logic [tap_pkg::BSR_LENGTH-1:0] coreValue,
	input wire logic [tap_pkg::BSR_LENGTH-1:0] coreEnable,
	output logic [tap_pkg::BSR_LENGTH-1:0] pinValue,
	output logic [tap_pkg::BSR_LENGTH-1:0] pinEnable
);

	// ==========================================================
	// Instruction decoding.
	function automatic logic selectsBoundary(tap_pkg::instr_t code);
		return code == tap_pkg::INSTR_EXTEST ||
			code == tap_pkg::INSTR_SAMPLE;
	endfunction : selectsBoundary

	function automatic logic selectsIdent(tap_pkg::instr_t code);
		return code == tap_pkg::INSTR_IDCODE;
	endfunction : selectsIdent

	// Unknown codes fall back to the bypass stage.
	function automatic logic selectsBypass(tap_pkg::instr_t code);
		return !selectsBoundary(code) && !selectsIdent(code);
	endfunction : selectsBypass

	// ==========================================================
	// Declarations.
	tap_pkg::tap_s tap_ff;
	tap_pkg::tap_s nxt_tap;
	tap_pkg::latch_s latch_ff;
	tap_pkg::latch_s nxt_latch;
	tap_pkg::mode_s modeTest;
	tap_pkg::mode_s modeSync;
	logic portDisabled;
	logic shiftIn;

	// ==========================================================
	// Feature-set select, brought onto the test clock.
	sync_agree #(
		.WIDTH(1)
	) featureSync (
		.clock(test_clock),
		.reset_n(test_reset_n),
		.asyncIn(feature_set_select),
		.syncOut(portDisabled)
	);

	assign shiftIn = test_serial_in;

	// ==========================================================
	// Controller and shift paths, rising test clock edge.
	always_comb begin
		nxt_tap = tap_ff;
		// Registers hold unless a state below says otherwise.
		case (tap_ff.state)
			tap_pkg::TEST_LOGIC_RESET: begin
				nxt_tap.state = test_mode_select ?
					tap_pkg::TEST_LOGIC_RESET :
					tap_pkg::RUN_TEST_IDLE;
			end
			tap_pkg::RUN_TEST_IDLE: begin
				nxt_tap.state = test_mode_select ?
					tap_pkg::SELECT_DR :
					tap_pkg::RUN_TEST_IDLE;
			end
			tap_pkg::SELECT_DR: begin
				nxt_tap.state = test_mode_select ?
					tap_pkg::SELECT_IR :
					tap_pkg::CAPTURE_DR;
			end
			tap_pkg::CAPTURE_DR: begin
				if (selectsBoundary(latch_ff.instr)) begin
					nxt_tap.bsrShift = pinSample;
				end else if (selectsIdent(latch_ff.instr)) begin
					nxt_tap.idShift = tap_pkg::ID_WORD;
				end else begin
					nxt_tap.bypassBit = 1'b0;
				end
				nxt_tap.state = test_mode_select ?
					tap_pkg::EXIT1_DR :
					tap_pkg::SHIFT_DR;
			end
			tap_pkg::SHIFT_DR: begin
				if (selectsBoundary(latch_ff.instr)) begin
					nxt_tap.bsrShift = {shiftIn,
						tap_ff.bsrShift[tap_pkg::BSR_LENGTH-1:1]};
				end else if (selectsIdent(latch_ff.instr)) begin
					nxt_tap.idShift = {shiftIn,
						tap_ff.idShift[tap_pkg::ID_WIDTH-1:1]};
				end else begin
					nxt_tap.bypassBit = shiftIn;
				end
				nxt_tap.state = test_mode_select ?
					tap_pkg::EXIT1_DR :
					tap_pkg::SHIFT_DR;
			end
			tap_pkg::EXIT1_DR: begin
				nxt_tap.state = test_mode_select ?
					tap_pkg::UPDATE_DR :
					tap_pkg::PAUSE_DR;
			end
			tap_pkg::PAUSE_DR: begin
				nxt_tap.state = test_mode_select ?
					tap_pkg::EXIT2_DR :
					tap_pkg::PAUSE_DR;
			end
			tap_pkg::EXIT2_DR: begin
				nxt_tap.state = test_mode_select ?
					tap_pkg::UPDATE_DR :
					tap_pkg::SHIFT_DR;
			end
			tap_pkg::UPDATE_DR: begin
				nxt_tap.state = test_mode_select ?
					tap_pkg::SELECT_DR :
					tap_pkg::RUN_TEST_IDLE;
			end
			tap_pkg::SELECT_IR: begin
				nxt_tap.state = test_mode_select ?
					tap_pkg::TEST_LOGIC_RESET :
					tap_pkg::CAPTURE_IR;
			end
			tap_pkg::CAPTURE_IR: begin
				nxt_tap.irShift = tap_pkg::IR_CAPTURE_VALUE;
				nxt_tap.state = test_mode_select ?
					tap_pkg::EXIT1_IR :
					tap_pkg::SHIFT_IR;
			end
			tap_pkg::SHIFT_IR: begin
				nxt_tap.irShift = {shiftIn,
					tap_ff.irShift[tap_pkg::IR_WIDTH-1:1]};
				nxt_tap.state = test_mode_select ?
					tap_pkg::EXIT1_IR :
					tap_pkg::SHIFT_IR;
			end
			tap_pkg::EXIT1_IR: begin
				nxt_tap.state = test_mode_select ?
					tap_pkg::UPDATE_IR :
					tap_pkg::PAUSE_IR;
			end
			tap_pkg::PAUSE_IR: begin
				nxt_tap.state = test_mode_select ?
					tap_pkg::EXIT2_IR :
					tap_pkg::PAUSE_IR;
			end
			// The usual controller graph is kept here: high updates.
			tap_pkg::EXIT2_IR: begin
				nxt_tap.state = test_mode_select ?
					tap_pkg::UPDATE_IR :
					tap_pkg::SHIFT_IR;
			end
			tap_pkg::UPDATE_IR: begin
				nxt_tap.state = test_mode_select ?
					tap_pkg::SELECT_DR :
					tap_pkg::RUN_TEST_IDLE;
			end
			default: begin
				nxt_tap.state = tap_pkg::TEST_LOGIC_RESET;
			end
		endcase
		// A disabled port sits in reset and leaves the pins alone.
		if (portDisabled) begin
			nxt_tap.state = tap_pkg::TEST_LOGIC_RESET;
		end
	end

	always_ff @(posedge test_clock or negedge test_reset_n) begin
		if (!test_reset_n) begin
			tap_ff <= '{state: tap_pkg::TEST_LOGIC_RESET,
				irShift: tap_pkg::IR_RESET_VALUE,
				bypassBit: 1'b0,
				idShift: tap_pkg::ID_WORD,
				bsrShift: '0};
		end else begin
			tap_ff <= nxt_tap;
		end
	end

	// ==========================================================
	// Output latches and serial output, falling test clock edge.
	always_comb begin
		nxt_latch = latch_ff;
		case (tap_ff.state)
			tap_pkg::TEST_LOGIC_RESET: begin
				nxt_latch.instr = tap_pkg::INSTR_IDCODE;
			end
			tap_pkg::UPDATE_IR: begin
				nxt_latch.instr = tap_ff.irShift;
			end
			tap_pkg::UPDATE_DR: begin
				if (selectsBoundary(latch_ff.instr)) begin
					nxt_latch.bsrLatch = tap_ff.bsrShift;
					nxt_latch.updateToggle = !latch_ff.updateToggle;
				end
			end
			default: begin
			end
		endcase
		// Data out changes only on the falling edge of a shift state.
		nxt_latch.serialOutEnable = 1'b0;
		if (tap_ff.state == tap_pkg::SHIFT_IR) begin
			nxt_latch.serialOut = tap_ff.irShift[0];
			nxt_latch.serialOutEnable = 1'b1;
		end else if (tap_ff.state == tap_pkg::SHIFT_DR) begin
			nxt_latch.serialOutEnable = 1'b1;
			if (selectsBoundary(latch_ff.instr)) begin
				nxt_latch.serialOut = tap_ff.bsrShift[0];
			end else if (selectsIdent(latch_ff.instr)) begin
				nxt_latch.serialOut = tap_ff.idShift[0];
			end else if (selectsBypass(latch_ff.instr)) begin
				nxt_latch.serialOut = tap_ff.bypassBit;
			end
		end
	end

	always_ff @(negedge test_clock or negedge test_reset_n) begin
		if (!test_reset_n) begin
			latch_ff <= '{instr: tap_pkg::IR_RESET_VALUE,
				bsrLatch: '0,
				updateToggle: 1'b0,
				serialOut: 1'b0,
				serialOutEnable: 1'b0};
		end else begin
			latch_ff <= nxt_latch;
		end
	end

	assign test_serial_out = latch_ff.serialOut;
	assign testSerialOutEnable = latch_ff.serialOutEnable;

	// ==========================================================
	// Test modes crossing to the functional clock.
	// Each is a level; the update toggle marks a settled scan word.
	always_comb begin
		modeTest.updateToggle = latch_ff.updateToggle;
		modeTest.drivePins = latch_ff.instr == tap_pkg::INSTR_EXTEST ||
			latch_ff.instr == tap_pkg::INSTR_CLAMP;
		modeTest.floatPins =
			latch_ff.instr == tap_pkg::INSTR_HIGHZ;
	end

	sync_agree #(
		.WIDTH(3)
	) modeCross (
		.clock(clock),
		.reset_n(reset_n),
		.asyncIn(modeTest),
		.syncOut(modeSync)
	);

	// The scan word is read only after its toggle has crossed, by
	// which time it has been still for several functional cycles.
	boundary_drive drive (
		.clock(clock),
		.reset_n(reset_n),
		.mode(modeSync),
		.scanWord(latch_ff.bsrLatch),
		.coreValue(coreValue),
		.coreEnable(coreEnable),
		.pinValue(pinValue),
		.pinEnable(pinEnable)
	);

endmodule : boundary_scan_tap

// File: core/tap_pkg.sv
/*
 * Shared constants and types of the boundary-scan test access port.
 * Assumes a test clock of its own and a separate functional clock.
 */
package tap_pkg;

	// ==========================================================
	// Sizes.
	localparam int IR_WIDTH = 3;
	localparam int ID_WIDTH = 32;
	localparam int BSR_LENGTH = 126;
	localparam int SYNC_STAGES = 3;

	// ==========================================================
	// Instruction codes.
	typedef logic [IR_WIDTH-1:0] instr_t;
	localparam instr_t INSTR_EXTEST = 3'h0;
	localparam instr_t INSTR_IDCODE = 3'h1;
	localparam instr_t INSTR_SAMPLE = 3'h2;
	localparam instr_t INSTR_CLAMP = 3'h3;
	localparam instr_t INSTR_HIGHZ = 3'h4;
	localparam instr_t INSTR_BYPASS = 3'h7;
	localparam instr_t IR_CAPTURE_VALUE = 3'h1;
	localparam instr_t IR_RESET_VALUE = INSTR_IDCODE;

	// ==========================================================
	// Identification word fields, least significant first.
	localparam logic ID_MARKER = 1'b1;
	// The maker, part and version values are arbitrary.
	localparam logic [10:0] ID_MAKER = 11'h2a5;
	localparam logic [15:0] ID_PART = 16'h5a3c;
	localparam logic [3:0] ID_VERSION = 4'h0;
	localparam logic [ID_WIDTH-1:0] ID_WORD =
		{ID_VERSION, ID_PART, ID_MAKER, ID_MARKER};

	// ==========================================================
	// Controller states, one-hot.
	typedef enum logic [15:0] {
		TEST_LOGIC_RESET = 16'h0001,
		RUN_TEST_IDLE = 16'h0002,
		SELECT_DR = 16'h0004,
		CAPTURE_DR = 16'h0008,
		SHIFT_DR = 16'h0010,
		EXIT1_DR = 16'h0020,
		PAUSE_DR = 16'h0040,
		EXIT2_DR = 16'h0080,
		UPDATE_DR = 16'h0100,
		SELECT_IR = 16'h0200,
		CAPTURE_IR = 16'h0400,
		SHIFT_IR = 16'h0800,
		EXIT1_IR = 16'h1000,
		PAUSE_IR = 16'h2000,
		EXIT2_IR = 16'h4000,
		UPDATE_IR = 16'h8000
	} tap_state_e;

	// ==========================================================
	// Rising-edge state of the test clock domain.
	typedef struct packed {
		tap_state_e state;
		instr_t irShift;
		logic bypassBit;
		logic [ID_WIDTH-1:0] idShift;
		logic [BSR_LENGTH-1:0] bsrShift;
	} tap_s;

	// Falling-edge state of the test clock domain.
	typedef struct packed {
		instr_t instr;
		logic [BSR_LENGTH-1:0] bsrLatch;
		logic updateToggle;
		logic serialOut;
		logic serialOutEnable;
	} latch_s;

	// Test modes handed to the functional clock domain.
	typedef struct packed {
		logic updateToggle;
		logic drivePins;
		logic floatPins;
	} mode_s;

	// Pin drive state in the functional clock domain.
	typedef struct packed {
		logic [BSR_LENGTH-1:0] heldWord;
		logic lastToggle;
		logic [BSR_LENGTH-1:0] pinValue;
		logic [BSR_LENGTH-1:0] pinEnable;
	} drive_s;

endpackage : tap_pkg

// File: core/sync_agree.sv
/*
 * Three-stage synchroniser for levels from another domain.
 * Assumes each bit is an independent level; the output moves only
 * when the second and third stages agree.
 */
module sync_agree #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	// ==========================================================
	// Stages.
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;
	logic [WIDTH-1:0] agreed_ff;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
			stage3_ff <= '0;
			agreed_ff <= '0;
		end else begin
			stage1_ff <= asyncIn;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_ff[i] == stage3_ff[i]) begin
					agreed_ff[i] <= stage3_ff[i];
				end
			end
		end
	end

	assign syncOut = agreed_ff;

endmodule : sync_agree

// File: core/boundary_drive.sv
/*
 * Functional clock side of the boundary cells: holds the updated
 * scan word and chooses between it and the system's own pin values.
 * Assumes the mode inputs are already synchronised to this clock and
 * that the scan word stays still while its update toggle crosses.
 */
module boundary_drive (
	input wire logic clock,
	input wire logic reset_n,
	input wire tap_pkg::mode_s mode,
	input wire logic [tap_pkg::BSR_LENGTH-1:0] scanWord,
	input wire logic [tap_pkg::BSR_LENGTH-1:0] coreValue,
	input wire logic [tap_pkg::BSR_LENGTH-1:0] coreEnable,
	output logic [tap_pkg::BSR_LENGTH-1:0] pinValue,
	output logic [tap_pkg::BSR_LENGTH-1:0] pinEnable
);

	tap_pkg::drive_s drive_ff;
	tap_pkg::drive_s nxt_drive;

	// ==========================================================
	// Next state.
	always_comb begin
		nxt_drive = drive_ff;
		nxt_drive.lastToggle = mode.updateToggle;
		// The word is copied only after its toggle has crossed.
		if (mode.updateToggle != drive_ff.lastToggle) begin
			nxt_drive.heldWord = scanWord;
		end
		if (mode.floatPins) begin
			nxt_drive.pinValue = coreValue;
			nxt_drive.pinEnable = '0;
		end else if (mode.drivePins) begin
			nxt_drive.pinValue = drive_ff.heldWord;
			nxt_drive.pinEnable = coreEnable;
		end else begin
			nxt_drive.pinValue = coreValue;
			nxt_drive.pinEnable = coreEnable;
		end
	end

	// ==========================================================
	// Registers.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			drive_ff <= '0;
		end else begin
			drive_ff <= nxt_drive;
		end
	end

	assign pinValue = drive_ff.pinValue;
	assign pinEnable = drive_ff.pinEnable;

endmodule : boundary_drive

// File: tb/boundary_scan_tap_asserts.sv
/*
 * Checker of the test access port, watching only its pins.
 * Assumes it is bound to boundary_scan_tap.
 */
module boundary_scan_tap_asserts (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic test_clock,
	input wire logic test_reset_n,
	input wire logic test_mode_select,
	input wire logic test_serial_in,
	input wire logic test_serial_out,
	input wire logic testSerialOutEnable,
	input wire logic feature_set_select,
	input wire logic [tap_pkg::BSR_LENGTH-1:0] pinSample,
	input wire logic [tap_pkg::BSR_LENGTH-1:0] coreValue,
	input wire logic [tap_pkg::BSR_LENGTH-1:0] coreEnable,
	input wire logic [tap_pkg::BSR_LENGTH-1:0] pinValue,
	input wire logic [tap_pkg::BSR_LENGTH-1:0] pinEnable
);
	timeunit 1ns;
	timeprecision 100ps;
	// ====================
	// Shadow controller, codes 0 reset, 3/4 capture/shift DR, 10/11 IR.
	localparam logic [63:0] NEXT_LOW = 64'h1bdd_bba1_4664_4311;
	localparam logic [63:0] NEXT_HIGH = 64'h2fef_cc02_8785_5920;
	logic [3:0] shadow_ff;
	logic [3:0] fssAge_ff;
	logic idActive_ff;
	logic [4:0] tlrCount_ff;
	logic quiet;
	// The shadow cannot know the disable synchroniser's delay, so it is
	// trusted only once the disable input has been low for a while.
	assign quiet = fssAge_ff[3];
	always_ff @(posedge test_clock or negedge test_reset_n) begin
		if (!test_reset_n) begin
			shadow_ff <= 4'h0;
			fssAge_ff <= 4'hf;
			idActive_ff <= 1'h1;
		end else begin
			if (feature_set_select)
				shadow_ff <= 4'h0;
			else if (test_mode_select)
				shadow_ff <= NEXT_HIGH[{shadow_ff, 2'h0} +: 4];
			else
				shadow_ff <= NEXT_LOW[{shadow_ff, 2'h0} +: 4];
			fssAge_ff <= feature_set_select ? 4'h0 :
				fssAge_ff + {3'h0, ~&fssAge_ff};
			idActive_ff <= (shadow_ff == 4'h0) |
				(idActive_ff & (shadow_ff != 4'hb));
		end
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			tlrCount_ff <= 5'h00;
		else if (shadow_ff != 4'h0 || !quiet)
			tlrCount_ff <= 5'h00;
		else if (tlrCount_ff != 5'h1f)
			tlrCount_ff <= tlrCount_ff + 5'h01;
	end
	// ====================
	// Assertions.
	a_enable_in_shift: assert property (@(posedge test_clock)
		disable iff (!test_reset_n || !quiet) testSerialOutEnable ==
		(shadow_ff == 4'h4 || shadow_ff == 4'hb))
		else $error("serial out enable disagrees with shift state");
	a_out_holds: assert property (@(posedge test_clock)
		disable iff (!test_reset_n) $past(test_reset_n) &&
		!testSerialOutEnable |-> $stable(test_serial_out))
		else $error("serial out moved outside a shift state");
	a_ir_capture_lsb: assert property (@(posedge test_clock)
		disable iff (!test_reset_n || !quiet) shadow_ff == 4'hb &&
		$past(shadow_ff) == 4'ha |-> test_serial_out == 1'h1)
		else $error("instruction capture bit zero is not one");
	a_id_lsb: assert property (@(posedge test_clock)
		disable iff (!test_reset_n || !quiet) shadow_ff == 4'h4 &&
		$past(shadow_ff) == 4'h3 && idActive_ff |-> test_serial_out)
		else $error("identification bit zero is not one");
	a_fss_disables: assert property (@(posedge test_clock)
		disable iff (!test_reset_n)
		feature_set_select [*6] |-> !testSerialOutEnable)
		else $error("port still shifting while disabled");
	a_reset_quiets: assert property (@(posedge clock)
		!test_reset_n [*2] |-> !testSerialOutEnable && !test_serial_out)
		else $error("serial out active during test reset");
	a_core_passes: assert property (@(posedge clock)
		disable iff (!reset_n) tlrCount_ff >= 5'h18 |->
		pinValue == $past(coreValue) && pinEnable == $past(coreEnable))
		else $error("pins do not follow the core in reset state");
	a_reset_pins: assert property (@(posedge clock)
		!reset_n [*2] |-> pinValue == '0 && pinEnable == '0)
		else $error("pins driven during functional reset");
	c_pause: cover property (@(posedge test_clock)
		shadow_ff == 4'h6 ##1 shadow_ff == 4'h7);
	c_fss: cover property (@(posedge test_clock) feature_set_select [*6]);
	c_pass: cover property (@(posedge clock) tlrCount_ff == 5'h1f);
endmodule : boundary_scan_tap_asserts

// File: tb/tap_tester.sv
/*
 * Model of the external boundary-scan tester.
 * Assumes the test clock stands low between steps.
 */
module tap_tester (
	output logic test_clock,
	output logic test_reset_n,
	output logic test_mode_select,
	output logic test_serial_in,
	input wire logic test_serial_out,
	input wire logic testSerialOutEnable
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		test_clock = 1'h0;
		test_reset_n = 1'h1;
		test_mode_select = 1'h1;
		test_serial_in = 1'h0;
	end
	// One test clock period; returns what the port showed before the rise.
	// An undriven serial out reads as unknown, so it can never match.
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		#1;
		tdo = testSerialOutEnable ? test_serial_out : 1'hx;
		test_mode_select <= tms;
		test_serial_in <= tdi;
		#31 test_clock = 1'h1;
		#32 test_clock = 1'h0;
	endtask : step
	task automatic hold_reset(input int ns);
		// A late start gives the reset a clean falling edge 1 ns after time zero.
		#1 test_reset_n = 1'h0;
		#(ns / 2) test_clock = 1'h1;
		#(ns / 2) test_clock = 1'h0;
		#1 test_reset_n = 1'h1;
	endtask : hold_reset
endmodule : tap_tester

// File: tb/tb.sv
/*
 * Self-checking bench of the test access port.
 * Assumes the tester model and the bound checker.
 */
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int N = tap_pkg::BSR_LENGTH;
	logic clock, reset_n, fss, b;
	logic test_clock, test_reset_n, test_mode_select, test_serial_in;
	logic test_serial_out, testSerialOutEnable;
	logic [N-1:0] pinSample, coreValue, coreEnable, pinValue, pinEnable;
	logic [N-1:0] heldQ, d;
	int n_fail, n_tests;
	always #5 clock = ~clock;
	tap_tester tester (.test_clock(test_clock), .test_reset_n(test_reset_n),
		.test_mode_select(test_mode_select),
		.test_serial_in(test_serial_in), .test_serial_out(test_serial_out),
		.testSerialOutEnable(testSerialOutEnable));
	boundary_scan_tap uut (.clock(clock), .reset_n(reset_n),
		.test_clock(test_clock), .test_reset_n(test_reset_n),
		.test_mode_select(test_mode_select),
		.test_serial_in(test_serial_in), .test_serial_out(test_serial_out),
		.testSerialOutEnable(testSerialOutEnable),
		.feature_set_select(fss), .pinSample(pinSample),
		.coreValue(coreValue), .coreEnable(coreEnable),
		.pinValue(pinValue), .pinEnable(pinEnable));
	// ====================
	// Shared tasks.
	task check(input logic [N-1:0] seen, input logic [N-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task summarize;
		if (n_fail == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	// Scan from idle back to idle; a pause after bit pauseAt if in range.
	task scan(input logic ir, input int n, input int pauseAt,
		input logic [N-1:0] din, output logic [N-1:0] dout);
		dout = '0;
		tester.step(1'h1, 1'h0, b);
		if (ir)
			tester.step(1'h1, 1'h0, b);
		tester.step(1'h0, 1'h0, b);
		tester.step(1'h0, 1'h0, b);
		for (int i = 0; i < n; i++) begin
			tester.step(i == n - 1 || i == pauseAt, din[i], b);
			dout[i] = b;
			// A pause after the last bit leaves through Exit2 to Update.
			if (i == pauseAt) begin
				tester.step(1'h0, 1'h0, b);
				tester.step(1'h0, 1'h0, b);
				tester.step(1'h1, 1'h0, b);
				tester.step(i == n - 1, 1'h0, b);
			end
		end
		if (pauseAt != n - 1)
			tester.step(1'h1, 1'h0, b);
		tester.step(1'h0, 1'h0, b);
	endtask : scan
	task set_ir(input tap_pkg::instr_t code);
		scan(1'h1, 3, 1, N'(code), d);
		check(d, N'(tap_pkg::IR_CAPTURE_VALUE));
	endtask : set_ir
	task read_id;
		scan(1'h0, 32, 5, '0, d);
		check(d, N'(tap_pkg::ID_WORD));
	endtask : read_id
	// ====================
	// Scenarios.
	task test_boundary;
		set_ir(tap_pkg::INSTR_SAMPLE);
		scan(1'h0, N, 60, ~heldQ, d);
		check(d, pinSample);
		set_ir(tap_pkg::INSTR_EXTEST);
		scan(1'h0, N, 90, heldQ, d);
		check(d, pinSample);
		repeat (30) @(posedge clock);
		check(pinValue, heldQ);
		check(pinEnable, coreEnable);
	endtask : test_boundary
	task test_modes;
		tap_pkg::instr_t codes[4];
		codes = '{tap_pkg::INSTR_CLAMP, tap_pkg::INSTR_HIGHZ,
			tap_pkg::INSTR_BYPASS, 3'h5};
		foreach (codes[k]) begin
			set_ir(codes[k]);
			scan(1'h0, 8, 7, N'(8'ha5), d);
			check(d, N'(8'h4a));
			repeat (30) @(posedge clock);
			check(pinValue, codes[k] == 3'h3 ? heldQ : coreValue);
			check(pinEnable, codes[k] == 3'h4 ? '0 : coreEnable);
		end
	endtask : test_modes
	task test_disable;
		tester.step(1'h1, 1'h0, b);
		tester.step(1'h0, 1'h0, b);
		tester.step(1'h0, 1'h0, b);
		tester.step(1'h0, 1'h0, b);
		check(N'(testSerialOutEnable), N'(1'h1));
		@(posedge clock) fss <= 1'h1;
		repeat (8) tester.step(1'h0, 1'h0, b);
		check(N'(testSerialOutEnable), '0);
		@(posedge clock) fss <= 1'h0;
		repeat (9) tester.step(1'h1, 1'h0, b);
		tester.step(1'h0, 1'h0, b);
		read_id();
	endtask : test_disable
	task test_reset;
		set_ir(tap_pkg::INSTR_BYPASS);
		// Linger in reset long enough for the mode levels to cross.
		repeat (8) tester.step(1'h1, 1'h0, b);
		check(pinValue, coreValue);
		check(pinEnable, coreEnable);
		tester.step(1'h0, 1'h0, b);
		read_id();
		set_ir(tap_pkg::INSTR_BYPASS);
		tester.hold_reset(64);
		tester.step(1'h0, 1'h0, b);
		read_id();
	endtask : test_reset
	// ====================
	// Main sequence and watchdog.
	initial begin
		clock = 1'h0;
		reset_n = 1'h0;
		fss = 1'h0;
		coreValue = {2{63'h7234_5678_9abc_def0}};
		coreEnable = {2{63'h0f0f_00ff_f0f0_3355}};
		pinSample = {2{63'h5a5a_c3c3_1e1e_6996}};
		heldQ = {2{63'h3c3c_a5a5_0ff0_9669}};
		n_fail = 0;
		n_tests = 0;
		tester.hold_reset(60);
		@(posedge clock) reset_n <= 1'h1;
		tester.step(1'h0, 1'h0, b);
		read_id();
		test_boundary();
		test_modes();
		test_disable();
		test_reset();
		summarize();
	end
	initial begin
		#800_000;
		n_fail++;
		summarize();
	end
endmodule : tb
bind boundary_scan_tap boundary_scan_tap_asserts chk (.clock(clock),
	.reset_n(reset_n), .test_clock(test_clock),
	.test_reset_n(test_reset_n), .test_mode_select(test_mode_select),
	.test_serial_in(test_serial_in), .test_serial_out(test_serial_out),
	.testSerialOutEnable(testSerialOutEnable),
	.feature_set_select(feature_set_select), .pinSample(pinSample),
	.coreValue(coreValue), .coreEnable(coreEnable),
	.pinValue(pinValue), .pinEnable(pinEnable));
